/* File: design/stc_synth_tuning_control.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_synth_tuning_control (
   input  wire logic                        clk_sys,
   input  wire logic                        nrst,
   input  wire logic [7:0]                  reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [31:0]                 reg_rdata,
   input  wire logic                        device_enable_input,
   input  wire logic                        mixer_select_pin,
   input  wire logic                        vtune_above_low,
   input  wire logic                        vtune_below_high,
   input  wire logic                        vco_above_target,
   input  wire logic [stc_pkg::CP_W-1:0]    vco_gain_code,
   output logic                             analog_enable,
   output logic                             mixer_first_enable,
   output logic                             mixer_second_enable,
   output logic                             bank_select,
   output logic      [1:0]                  vco_select,
   output logic      [6:0]                  vco_band,
   output logic                             loop_enable,
   output logic      [stc_pkg::CP_W-1:0]    pump_current,
   output logic      [2:0]                  ref_div_ratio,
   output logic      [2:0]                  lo_div_code,
   output logic      [stc_pkg::NINT_W-1:0]  feedback_int,
   output logic                             prescaler_modulus,
   output logic                             general_output_four,
   output logic                             lock_flag
);

   // Picks one of three oscillators from the integer divide value.
   function automatic logic [1:0] vco_pick(input logic [stc_pkg::NINT_W-1:0] nint);
      if (nint < stc_pkg::VCO_EDGE_1) begin
         vco_pick = 2'h0;
      end else if (nint < stc_pkg::VCO_EDGE_2) begin
         vco_pick = 2'h1;
      end else begin
         vco_pick = 2'h2;
      end
   endfunction : vco_pick

   // Keeps a divider code inside its legal range.
   function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] lo,
                                          input logic [2:0] hi);
      if (v < lo) begin
         clamp3 = lo;
      end else if (v > hi) begin
         clamp3 = hi;
      end else begin
         clamp3 = v;
      end
   endfunction : clamp3

   // ---------------- Input synchronisers ----------------
   logic [stc_pkg::SYNC_W-1:0] sync1_r, sync2_r, sync3_r, filt_r;
   logic [stc_pkg::SYNC_W-1:0] filt_nxt;
   logic                       pin_en, pin_mode, win_lo, win_hi, above;
   logic [stc_pkg::CP_W-1:0]   gain;

   // A bit is accepted once the second and third stages agree.
   always_comb begin
      filt_nxt = ((sync2_r ~^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & filt_r);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         filt_r  <= '0;
      end else begin
         sync1_r <= {vco_gain_code, vco_above_target, vtune_below_high, vtune_above_low,
                     mixer_select_pin, device_enable_input};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r  <= filt_nxt;
      end
   end

   assign pin_en   = filt_r[0];
   assign pin_mode = filt_r[1];
   assign win_lo   = filt_r[2];
   assign win_hi   = filt_r[3];
   assign above    = filt_r[4];
   assign gain     = filt_r[10:5];

   // ---------------- Register file ----------------
   logic [stc_pkg::CTL_W-1:0] ctrl_r, ctrl_nxt;
   logic [stc_pkg::FRQ_W-1:0] freq_r [2];
   logic [stc_pkg::FRQ_W-1:0] freq_nxt [2];
   logic [stc_pkg::CFG_W-1:0] cfg_r [2];
   logic [stc_pkg::CFG_W-1:0] cfg_nxt [2];
   logic [31:0]               rdata_r, rdata_nxt;
   logic                      seq_start;
   logic [31:0]               readback;

   // Writes store fields; relock clears itself on start unless written again.
   always_comb begin
      ctrl_nxt = ctrl_r;
      freq_nxt = freq_r;
      cfg_nxt  = cfg_r;
      rdata_nxt = 32'h00000000;
      if (seq_start) begin
         ctrl_nxt[stc_pkg::CTL_RELOCK] = 1'b0;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            stc_pkg::OFS_CTRL:    ctrl_nxt    = reg_wdata[stc_pkg::CTL_W-1:0];
            stc_pkg::OFS_B1_FREQ: freq_nxt[0] = reg_wdata[stc_pkg::FRQ_W-1:0];
            stc_pkg::OFS_B1_CFG:  cfg_nxt[0]  = reg_wdata[stc_pkg::CFG_W-1:0];
            stc_pkg::OFS_B2_FREQ: freq_nxt[1] = reg_wdata[stc_pkg::FRQ_W-1:0];
            stc_pkg::OFS_B2_CFG:  cfg_nxt[1]  = reg_wdata[stc_pkg::CFG_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            stc_pkg::OFS_CTRL:     rdata_nxt = {24'h000000, ctrl_r};
            stc_pkg::OFS_B1_FREQ:  rdata_nxt = {7'h00, freq_r[0]};
            stc_pkg::OFS_B1_CFG:   rdata_nxt = {20'h00000, cfg_r[0]};
            stc_pkg::OFS_B2_FREQ:  rdata_nxt = {7'h00, freq_r[1]};
            stc_pkg::OFS_B2_CFG:   rdata_nxt = {20'h00000, cfg_r[1]};
            stc_pkg::OFS_READBACK: rdata_nxt = readback;
            default:               rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_r    <= stc_pkg::CTRL_RST;
         freq_r[0] <= stc_pkg::FREQ_RST;
         freq_r[1] <= stc_pkg::FREQ_RST;
         cfg_r[0]  <= stc_pkg::CFG_RST;
         cfg_r[1]  <= stc_pkg::CFG_RST;
         rdata_r   <= 32'h00000000;
      end else begin
         ctrl_r  <= ctrl_nxt;
         freq_r  <= freq_nxt;
         cfg_r   <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ---------------- Source selection ----------------
   logic sw_ctrl, eff_en, eff_mode, soft_rst, full_duplex_bit, bank;

   assign sw_ctrl  = ctrl_r[stc_pkg::CTL_SW_CTRL];
   assign eff_en   = sw_ctrl ? ctrl_r[stc_pkg::CTL_SW_EN] : pin_en;
   assign eff_mode = sw_ctrl ? ctrl_r[stc_pkg::CTL_SW_MODE] : pin_mode;
   assign soft_rst = sw_ctrl & ctrl_r[stc_pkg::CTL_SW_RST];
   assign full_duplex_bit    = ctrl_r[stc_pkg::CTL_FULL_DUPLEX_BIT];
   assign bank     = eff_mode;

   // ---------------- Tuning engine ----------------
   stc_pkg::stc_state_type      state_r, state_nxt;
   logic                        en_prev_r, en_prev_nxt;
   logic [2:0]                  pd_cnt_r, pd_cnt_nxt;
   logic                        pd_tick;
   logic [6:0]                  band_r, band_nxt;
   logic [2:0]                  settle_r, settle_nxt;
   logic [1:0]                  vco_r, vco_nxt;
   logic                        fail_r, fail_nxt;
   logic                        loop_r, loop_nxt;
   logic [stc_pkg::CP_W-1:0]    cal_cp_r, cal_cp_nxt;
   logic [stc_pkg::CP_W-1:0]    cp_r, cp_nxt;
   logic                        mix1_r, mix1_nxt, mix2_r, mix2_nxt, bank_r, bank_nxt;
   logic [2:0]                  ref_r, ref_nxt, lo_r, lo_nxt;
   logic [stc_pkg::FRAC_W-1:0]  acc_r, acc_nxt;
   logic [15:0]                 lfsr_r, lfsr_nxt;
   logic [stc_pkg::NINT_W-1:0]  nint_r, nint_nxt;
   logic                        mod_r, mod_nxt;
   logic                        lock_r, lock_nxt, general_output_four_r, general_output_four_nxt, aen_r, aen_nxt;
   logic [stc_pkg::FRAC_W:0]    acc_sum;
   logic [stc_pkg::FRQ_W-1:0]   act_freq;
   logic [stc_pkg::CFG_W-1:0]   act_cfg;

   assign act_freq = freq_r[bank];
   assign act_cfg  = cfg_r[bank];
   assign pd_tick  = (pd_cnt_r == 3'h0);
   assign seq_start = (eff_en & ~en_prev_r) | ctrl_r[stc_pkg::CTL_RELOCK];
   assign acc_sum  = {1'b0, acc_r} + {1'b0, act_freq[stc_pkg::FRAC_W-1:0]}
                     + {16'h0000, lfsr_r[0]};

   // Sequencing, mixer routing, dividers and lock reporting.
   always_comb begin
      state_nxt   = state_r;
      en_prev_nxt = eff_en;
      band_nxt    = band_r;
      // The comparator lags the band by its synchroniser, so each step waits it out.
      settle_nxt  = (settle_r == 3'h0) ? 3'h0 : settle_r - 3'h1;
      vco_nxt     = vco_r;
      fail_nxt    = fail_r;
      loop_nxt    = loop_r;
      cal_cp_nxt  = cal_cp_r;
      acc_nxt     = acc_r;
      lfsr_nxt    = lfsr_r;
      mod_nxt     = mod_r;
      // Phase-detector tick counts the reference divider ratio.
      ref_nxt    = clamp3(act_cfg[stc_pkg::CFG_REF_LSB +: 3], 3'h1, 3'h7);
      pd_cnt_nxt = pd_tick ? ref_r - 3'h1 : pd_cnt_r - 3'h1;
      lo_nxt     = clamp3(act_cfg[stc_pkg::CFG_LO_LSB +: 3], stc_pkg::LO_CODE_MIN,
                          stc_pkg::LO_CODE_MAX);
      bank_nxt   = bank;
      mix1_nxt   = full_duplex_bit | ~bank;
      mix2_nxt   = full_duplex_bit | bank;
      nint_nxt   = act_freq[stc_pkg::FRQ_INT_LSB +: stc_pkg::NINT_W];
      aen_nxt    = eff_en;
      unique case (state_r)
         stc_pkg::ST_IDLE: ;
         stc_pkg::ST_PICK: begin
            vco_nxt   = vco_pick(act_freq[stc_pkg::FRQ_INT_LSB +: stc_pkg::NINT_W]);
            band_nxt  = stc_pkg::BAND_LOW;
            settle_nxt = stc_pkg::BAND_SETTLE;
            state_nxt = stc_pkg::ST_BAND;
         end
         stc_pkg::ST_BAND: begin
            if (pd_tick && settle_r == 3'h0) begin
               if (!above) begin
                  fail_nxt  = (band_r == stc_pkg::BAND_LOW) ||
                              (band_r == stc_pkg::BAND_HIGH);
                  state_nxt = ctrl_r[stc_pkg::CTL_BWCAL] ? stc_pkg::ST_BWCAL
                                                         : stc_pkg::ST_LOCK;
               end else if (band_r == stc_pkg::BAND_HIGH) begin
                  fail_nxt  = 1'b1;
                  state_nxt = ctrl_r[stc_pkg::CTL_BWCAL] ? stc_pkg::ST_BWCAL
                                                         : stc_pkg::ST_LOCK;
               end else begin
                  band_nxt = band_r + 7'h01;
                  settle_nxt = stc_pkg::BAND_SETTLE;
               end
            end
         end
         stc_pkg::ST_BWCAL: begin
            if (pd_tick) begin
               cal_cp_nxt = gain;
               state_nxt  = stc_pkg::ST_LOCK;
            end
         end
         stc_pkg::ST_LOCK: loop_nxt = 1'b1;
      endcase
      if (seq_start && eff_en) begin
         state_nxt = stc_pkg::ST_PICK;
         loop_nxt  = 1'b0;
         fail_nxt  = 1'b0;
      end
      if (!eff_en || soft_rst) begin
         state_nxt = stc_pkg::ST_IDLE;
         loop_nxt  = 1'b0;
      end
      if (soft_rst) begin
         aen_nxt = 1'b0;
      end
      // Pump current comes from the bank field, or from calibration when enabled.
      cp_nxt = (ctrl_r[stc_pkg::CTL_BWCAL] && loop_r) ? cal_cp_r
               : act_cfg[stc_pkg::CFG_CP_LSB +: stc_pkg::CP_W];
      // Dithered accumulator drives the dual-modulus prescaler each comparison while the loop is closed.
      if (pd_tick && loop_r) begin
         acc_nxt  = acc_sum[stc_pkg::FRAC_W-1:0];
         mod_nxt  = acc_sum[stc_pkg::FRAC_W];
         lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
      lock_nxt = loop_r & win_lo & win_hi;
      general_output_four_nxt = ctrl_r[stc_pkg::CTL_GENERAL_OUTPUT_FOUR_LCK] & lock_r;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r   <= stc_pkg::ST_IDLE;
         en_prev_r <= 1'b0;
         pd_cnt_r  <= 3'h0;
         band_r    <= stc_pkg::BAND_LOW;
         settle_r  <= 3'h0;
         vco_r     <= 2'h0;
         fail_r    <= 1'b0;
         loop_r    <= 1'b0;
         cal_cp_r  <= stc_pkg::CP_RST;
         cp_r      <= stc_pkg::CP_RST;
         mix1_r    <= 1'b0;
         mix2_r    <= 1'b0;
         bank_r    <= 1'b0;
         ref_r     <= stc_pkg::REF_DIV_RST;
         lo_r      <= stc_pkg::LO_CODE_RST;
         acc_r     <= 16'h0000;
         lfsr_r    <= 16'hACE1;
         nint_r    <= 9'h000;
         mod_r     <= 1'b0;
         lock_r    <= 1'b0;
         general_output_four_r    <= 1'b0;
         aen_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         en_prev_r <= en_prev_nxt;
         pd_cnt_r  <= pd_cnt_nxt;
         band_r    <= band_nxt;
         settle_r  <= settle_nxt;
         vco_r     <= vco_nxt;
         fail_r    <= fail_nxt;
         loop_r    <= loop_nxt;
         cal_cp_r  <= cal_cp_nxt;
         cp_r      <= cp_nxt;
         mix1_r    <= mix1_nxt;
         mix2_r    <= mix2_nxt;
         bank_r    <= bank_nxt;
         ref_r     <= ref_nxt;
         lo_r      <= lo_nxt;
         acc_r     <= acc_nxt;
         lfsr_r    <= lfsr_nxt;
         nint_r    <= nint_nxt;
         mod_r     <= mod_nxt;
         lock_r    <= lock_nxt;
         general_output_four_r    <= general_output_four_nxt;
         aen_r     <= aen_nxt;
      end
   end

   // Readback word gathers code, fail, lock, oscillator, pump and busy.
   assign readback = {14'h0000, (state_r != stc_pkg::ST_IDLE && !loop_r), cp_r, vco_r,
                      lock_r, fail_r, band_r};

   assign reg_rdata           = rdata_r;
   assign analog_enable       = aen_r;
   assign mixer_first_enable  = mix1_r;
   assign mixer_second_enable = mix2_r;
   assign bank_select         = bank_r;
   assign vco_select          = vco_r;
   assign vco_band            = band_r;
   assign loop_enable         = loop_r;
   assign pump_current        = cp_r;
   assign ref_div_ratio       = ref_r;
   assign lo_div_code         = lo_r;
   assign feedback_int        = nint_r;
   assign prescaler_modulus   = mod_r;
   assign general_output_four = general_output_four_r;
   assign lock_flag           = lock_r;

endmodule : stc_synth_tuning_control
`default_nettype wire

/* File: design/stc_pkg.sv */
package stc_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_B1_FREQ  = 8'h04;
   localparam logic [7:0] OFS_B1_CFG   = 8'h08;
   localparam logic [7:0] OFS_B2_FREQ  = 8'h0C;
   localparam logic [7:0] OFS_B2_CFG   = 8'h10;
   localparam logic [7:0] OFS_READBACK = 8'h14;

   // Control register field positions.
   localparam int CTL_SW_CTRL  = 0;
   localparam int CTL_SW_EN    = 1;
   localparam int CTL_SW_MODE  = 2;
   localparam int CTL_SW_RST   = 3;
   localparam int CTL_FULL_DUPLEX_BIT    = 4;
   localparam int CTL_RELOCK   = 5;
   localparam int CTL_BWCAL    = 6;
   localparam int CTL_GENERAL_OUTPUT_FOUR_LCK = 7;
   localparam int CTL_W        = 8;

   // Bank frequency word: fraction in [15:0], integer in [24:16].
   localparam int FRQ_FRAC_LSB = 0;
   localparam int FRQ_INT_LSB  = 16;
   localparam int FRAC_W       = 16;
   localparam int NINT_W       = 9;
   localparam int FRQ_W        = 25;

   // Bank configuration word: pump [5:0], reference divider [8:6], output divider [11:9].
   localparam int CFG_CP_LSB   = 0;
   localparam int CFG_REF_LSB  = 6;
   localparam int CFG_LO_LSB   = 9;
   localparam int CFG_W        = 12;
   localparam int CP_W         = 6;

   // Readback field positions.
   localparam int RB_CODE_LSB  = 0;
   localparam int RB_FAIL      = 7;
   localparam int RB_LOCK      = 8;
   localparam int RB_VCO_LSB   = 9;
   localparam int RB_CP_LSB    = 11;
   localparam int RB_BUSY      = 17;

   // Reset values.
   localparam logic [CTL_W-1:0] CTRL_RST     = 8'h00;
   localparam logic [FRQ_W-1:0] FREQ_RST     = 25'h0000000;
   localparam logic [CP_W-1:0]  CP_RST       = 6'h1F;
   localparam logic [2:0]       REF_DIV_RST  = 3'h1;
   localparam logic [2:0]       LO_CODE_RST  = 3'h1;
   localparam logic [CFG_W-1:0] CFG_RST      = {LO_CODE_RST, REF_DIV_RST, CP_RST};

   // Band code limits.
   localparam logic [6:0] BAND_LOW  = 7'h00;
   localparam logic [6:0] BAND_HIGH = 7'h7F;

   // Clocks to wait after a band change before the comparator is trusted.
   localparam logic [2:0] BAND_SETTLE = 3'h4;

   // Output divider codes: 1 is /2 up to 5 is /32.
   localparam logic [2:0] LO_CODE_MIN = 3'h1;
   localparam logic [2:0] LO_CODE_MAX = 3'h5;

   // Integer-divide edges that hand over between the three oscillators.
   localparam logic [NINT_W-1:0] VCO_EDGE_1 = 9'h050;
   localparam logic [NINT_W-1:0] VCO_EDGE_2 = 9'h070;

   // Synchronised input count: enable, mode, window low, window high, above, gain[5:0].
   localparam int SYNC_W = 11;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PICK,
      ST_BAND,
      ST_BWCAL,
      ST_LOCK
   } stc_state_type;

endpackage : stc_pkg

/* File: tb/stc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_monitor (
   input wire logic                     clk_sys,
   input wire logic                     nrst,
   input wire logic [7:0]               reg_addr,
   input wire logic                     reg_rd,
   input wire logic [31:0]              reg_rdata,
   input wire logic                     analog_enable,
   input wire logic                     mixer_first_enable,
   input wire logic                     mixer_second_enable,
   input wire logic                     bank_select,
   input wire logic [1:0]               vco_select,
   input wire logic [6:0]               vco_band,
   input wire logic                     loop_enable,
   input wire logic [stc_pkg::CP_W-1:0] pump_current,
   input wire logic [2:0]               ref_div_ratio,
   input wire logic [2:0]               lo_div_code,
   input wire logic                     general_output_four,
   input wire logic                     lock_flag
);
   logic [6:0] band_q_r;
   logic [3:0] gap_r;
   logic [3:0] gap_nxt;

   // Counts the clocks for which the band has stood still.
   always_comb begin
      gap_nxt = gap_r;
      if (vco_band != band_q_r) begin
         gap_nxt = 4'h0;
      end else if (gap_r != 4'hF) begin
         gap_nxt = gap_r + 4'h1;
      end
   end

   // Registers the previous band and the idle count.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         band_q_r <= 7'h00;
         gap_r    <= 4'h0;
      end else begin
         band_q_r <= vco_band;
         gap_r    <= gap_nxt;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // A readback request followed by the cycle that carries its data.
   sequence s_rb;
      reg_rd && reg_addr == stc_pkg::OFS_READBACK ##1 1'b1;
   endsequence
   // One band step up from a band that was itself reached by a step.
   sequence s_step;
      ({1'b0, vco_band} == {1'b0, band_q_r} + 8'h01) && band_q_r != 7'h00;
   endsequence

   property p_rb_fields;
      s_rb |-> reg_rdata[6:0] == $past(vco_band) && reg_rdata[8] == $past(lock_flag)
         && reg_rdata[10:9] == $past(vco_select) && reg_rdata[16:11] == $past(pump_current);
   endproperty
   a_rb_fields: assert property (p_rb_fields) else $error("readback fields wrong");
   property p_rb_fail;
      s_rb |-> reg_rdata[7] == 1'b0 || reg_rdata[6:0] == 7'h00 || reg_rdata[6:0] == 7'h7F;
   endproperty
   a_rb_fail: assert property (p_rb_fail) else $error("fail flag with good code");
   property p_band_hold;
      loop_enable && $past(loop_enable) |-> $stable(vco_band);
   endproperty
   a_band_hold: assert property (p_band_hold) else $error("band moved while locking");
   property p_lock;
      lock_flag |-> $past(loop_enable);
   endproperty
   a_lock: assert property (p_lock) else $error("lock without loop");
   property p_gpo;
      general_output_four |-> lock_flag || $past(lock_flag);
   endproperty
   a_gpo: assert property (p_gpo) else $error("output four without lock");
   property p_mix;
      mixer_first_enable != mixer_second_enable |-> mixer_second_enable == bank_select;
   endproperty
   a_mix: assert property (p_mix) else $error("mixer and bank differ");
   property p_start;
      $rose(analog_enable) |-> ##[0:6] (vco_band == 7'h00);
   endproperty
   a_start: assert property (p_start) else $error("search not restarted");
   property p_div;
      ref_div_ratio != 3'h0 && lo_div_code inside {[3'h1:3'h5]};
   endproperty
   a_div: assert property (p_div) else $error("divider out of range");
   property p_step;
      s_step |-> gap_r >= 4'h4;
   endproperty
   a_step: assert property (p_step) else $error("band step off detector rate");
endmodule : stc_monitor

bind stc_synth_tuning_control stc_monitor i_stc_monitor (.clk_sys, .nrst, .reg_addr,
   .reg_rd, .reg_rdata, .analog_enable, .mixer_first_enable, .mixer_second_enable,
   .bank_select, .vco_select, .vco_band, .loop_enable, .pump_current, .ref_div_ratio,
   .lo_div_code, .general_output_four, .lock_flag);
`default_nettype wire

/* File: tb/stc_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_analog_model (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic [6:0] vco_band,
   input  wire logic       loop_enable,
   input  wire logic [7:0] target_band,
   output logic            vco_above_target,
   output logic            vtune_above_low,
   output logic            vtune_below_high
);
   logic [2:0] settle;

   // The oscillator runs fast until the band reaches the target band.
   assign vco_above_target = {1'b0, vco_band} < target_band;
   // The tuning voltage sits on the upper rail until the loop has settled.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst || !loop_enable) begin
         settle <= 3'h0;
      end else if (settle != 3'h7) begin
         settle <= settle + 3'h1;
      end
   end
   assign vtune_above_low  = 1'b1;
   assign vtune_below_high = (settle == 3'h7);
endmodule : stc_analog_model
`default_nettype wire

/* File: tb/stc_synth_tuning_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module stc_synth_tuning_control_bench;
   localparam logic [39:0] TGTS = 40'hC8_00_7E_01_28;
   localparam logic [59:0] INTS = 60'h020_060_100_060_020;
   logic        clk_sys, nrst, reg_wr, reg_rd, device_enable_input, mixer_select_pin;
   logic        vtune_above_low, vtune_below_high, vco_above_target, analog_enable;
   logic        mixer_first_enable, mixer_second_enable, bank_select, loop_enable;
   logic        prescaler_modulus, general_output_four, lock_flag;
   logic [7:0]  reg_addr, tgt;
   logic [31:0] reg_wdata, reg_rdata;
   logic [5:0]  vco_gain_code, pump_current;
   logic [1:0]  vco_select;
   logic [6:0]  vco_band;
   logic [2:0]  ref_div_ratio, lo_div_code;
   logic [8:0]  feedback_int;
   int          mismatches = 0, num_checks = 0, cyc_count = 0;

   stc_synth_tuning_control i_stc_synth_tuning_control (.clk_sys, .nrst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .device_enable_input, .mixer_select_pin,
      .vtune_above_low, .vtune_below_high, .vco_above_target, .vco_gain_code,
      .analog_enable, .mixer_first_enable, .mixer_second_enable, .bank_select, .vco_select,
      .vco_band, .loop_enable, .pump_current, .ref_div_ratio, .lo_div_code, .feedback_int,
      .prescaler_modulus, .general_output_four, .lock_flag);
   stc_analog_model i_stc_analog_model (.clk_sys, .nrst, .vco_band, .loop_enable,
      .target_band(tgt), .vco_above_target, .vtune_above_low, .vtune_below_high);

   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Cuts a hung run short.
   always @(posedge clk_sys) begin
      cyc_count++;
      if (cyc_count == 30000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Polls the busy bit, lets the loop settle, then fetches the readback word.
   task automatic wait_idle(output logic [31:0] r);
      int k;
      for (k = 0; k < 600; k++) begin
         rd(stc_pkg::OFS_READBACK, r);
         if (r[17] === 1'b0) break;
      end
      `CHK("busy", 1'b0, r[17])
      repeat (24) @(posedge clk_sys);
      rd(stc_pkg::OFS_READBACK, r);
   endtask : wait_idle

   // Programs bank one, then drops and raises the enable pin to start a search.
   task automatic cal(input logic [7:0] t, input logic [8:0] n, output logic [31:0] r);
      wr(stc_pkg::OFS_B1_FREQ, {7'h00, n, 16'h0000});
      tgt                 <= t;
      device_enable_input <= 1'b0;
      repeat (8) @(posedge clk_sys);
      device_enable_input <= 1'b1;
      repeat (8) @(posedge clk_sys);
      wait_idle(r);
   endtask : cal

   task automatic t_reset();
      logic [31:0] r;
      `CHK("pump", 6'h1F, pump_current)
      `CHK("lo", 3'h1, lo_div_code)
      rd(stc_pkg::OFS_B1_CFG, r);
      `CHK("cfg1", 32'h0000025F, r)
      rd(stc_pkg::OFS_CTRL, r);
      `CHK("ctrl", 32'h00000000, r)
      rd(8'h40, r);
      `CHK("unmapped", 32'h00000000, r)
   endtask : t_reset

   task automatic t_search();
      int          i;
      logic [31:0] r;
      logic [7:0]  t;
      logic [8:0]  n;
      logic [6:0]  c;
      logic [1:0]  v;
      for (i = 0; i < 5; i++) begin
         t = TGTS[8*i +: 8];
         n = INTS[12*i +: 9];
         c = (t > 8'h7E) ? 7'h7F : t[6:0];
         cal(t, n, r);
         `CHK("code", c, r[6:0])
         `CHK("fail", (c == 7'h00 || c == 7'h7F), r[7])
         v = (n < stc_pkg::VCO_EDGE_1) ? 2'h0 : ((n < stc_pkg::VCO_EDGE_2) ? 2'h1 : 2'h2);
         `CHK("vco", v, r[10:9])
         `CHK("nint", n, feedback_int)
         if (c != 7'h00 && c != 7'h7F) `CHK("lock", 1'b1, lock_flag)
      end
   endtask : t_search

   task automatic t_divs();
      logic [31:0] r;
      wr(stc_pkg::OFS_B1_CFG, 32'h00000BFF);
      repeat (2) @(posedge clk_sys);
      `CHK("pump", 6'h3F, pump_current)
      `CHK("ref", 3'h7, ref_div_ratio)
      `CHK("lo", 3'h5, lo_div_code)
      cal(8'h0A, 9'h020, r);
      `CHK("code", 7'h0A, r[6:0])
      wr(stc_pkg::OFS_B1_CFG, 32'h00000E1F);
      repeat (2) @(posedge clk_sys);
      `CHK("ref", 3'h1, ref_div_ratio)
      `CHK("lo", 3'h5, lo_div_code)
      wr(stc_pkg::OFS_B1_CFG, 32'h0000025F);
   endtask : t_divs

   task automatic t_relock();
      logic [31:0] r;
      tgt <= 8'h32;
      wr(stc_pkg::OFS_CTRL, 32'h00000020);
      repeat (3) @(posedge clk_sys);
      rd(stc_pkg::OFS_CTRL, r);
      `CHK("relock", 32'h00000000, r)
      wait_idle(r);
      `CHK("code", 7'h32, r[6:0])
   endtask : t_relock

   task automatic t_mixer();
      int i;
      wr(stc_pkg::OFS_B2_CFG, 32'h00000245);
      for (i = 0; i < 4; i++) begin
         wr(stc_pkg::OFS_CTRL, {27'h0, i[1], 4'h0});
         mixer_select_pin <= i[0];
         repeat (8) @(posedge clk_sys);
         `CHK("bank", i[0], bank_select)
         `CHK("mix1", i[1] | ~i[0], mixer_first_enable)
         `CHK("mix2", i[1] | i[0], mixer_second_enable)
         `CHK("pump", i[0] ? 6'h05 : 6'h1F, pump_current)
      end
      mixer_select_pin <= 1'b0;
      wr(stc_pkg::OFS_CTRL, 32'h00000007);
      repeat (8) @(posedge clk_sys);
      `CHK("swbank", 1'b1, bank_select)
      wr(stc_pkg::OFS_CTRL, 32'h00000009);
      repeat (3) @(posedge clk_sys);
      `CHK("swrst", 1'b0, analog_enable | loop_enable)
      wr(stc_pkg::OFS_CTRL, 32'h00000000);
   endtask : t_mixer

   task automatic t_bwcal();
      logic [31:0] r;
      vco_gain_code <= 6'h0C;
      wr(stc_pkg::OFS_CTRL, 32'h000000C0);
      cal(8'h1E, 9'h020, r);
      `CHK("calpump", 6'h0C, pump_current)
      `CHK("gpo", 1'b1, general_output_four)
      `CHK("rblock", 1'b1, r[8])
      wr(stc_pkg::OFS_CTRL, 32'h00000000);
   endtask : t_bwcal

   // Main sequence.
   initial begin
      nrst                = 1'b0;
      reg_wr              = 1'b0;
      reg_rd              = 1'b0;
      reg_addr            = 8'h00;
      reg_wdata           = 32'h00000000;
      device_enable_input = 1'b0;
      mixer_select_pin    = 1'b0;
      vco_gain_code       = 6'h00;
      tgt                 = 8'h00;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_search();
      t_divs();
      t_relock();
      t_mixer();
      t_bwcal();
      end_of_test();
   end
endmodule : stc_synth_tuning_control_bench
`default_nettype wire
